// ===== rtl/bosr_readout.sv
// staging fifo and register readout of the barometer result path
// assumes conversions and register reads come from core_clk logic
//
// Notes on behaviour
// - threshold flag bit 7 high while queue count >= programmed threshold.
// - overwrite flag bit 6 high once full queue lost a sample.
// - filled flag bit 5 high when queue full and nothing overwritten.
// - temperature overrun bit 5 set when unread temperature is replaced.
// - pressure overrun bit 4 set when unread pressure is replaced.
// - temperature available bit 1 set on fresh temperature result.
// - pressure available bit 0 set on fresh pressure result.
// - available flags set when a new result lands, overrun flags when it replaces an unread one; reading 2Ah clears the pressure ones, 2Ch the temperature ones.
// - pressure is 24-bit two's complement at 28h, 29h, 2Ah.
// - with all reference functions off, pressure minus stored offset.
// - temperature is 16-bit two's complement at 2Bh and 2Ch.
// - reading 3Ch resets the pressure low-pass filter.
// - oldest queued pressure read at 78h, 79h, 7Ah.
// - its paired queued temperature read at 7Bh, 7Ch.
// - queue holds at most 128 samples, count reaches 128 when full.
// - threshold is a 7-bit field resetting to zero.
// - pressure offset is 16-bit two's complement.
`timescale 1ns/1ps

// ----------------------------------------
// staging fifo
// ----------------------------------------
module bosr_fifo #(
  parameter int DW = 40,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [DW-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [DW-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic in_ready_r;
  logic out_valid_r;
  wire push = in_valid & in_ready_r;
  wire pop = out_valid_r & out_ready;

  assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);
  assign in_ready = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data = mem[rd_ptr_r];

  always_ff @(posedge core_clk)
  begin
    if (ce && push)
    begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      in_ready_r <= 1'b0;
      out_valid_r <= 1'b0;
    end
    else if (ce)
    begin
      wr_ptr_r <= wr_ptr_r + AW'(push);
      rd_ptr_r <= rd_ptr_r + AW'(pop);
      cnt_r <= cnt_nxt;
      in_ready_r <= cnt_nxt != CW'(DEPTH);
      out_valid_r <= cnt_nxt != '0;
    end
  end
endmodule : bosr_fifo

// ----------------------------------------
// readout top
// ----------------------------------------
module bosr_readout (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic conv_valid,
  output logic conv_ready,
  input wire bosr_pkg::bosr_sample_s conv_sample,
  input wire logic cfg_wr,
  input wire logic [bosr_pkg::THR_W-1:0] threshold_level,
  input wire logic [bosr_pkg::OFFSET_W-1:0] press_offset_value,
  input wire logic differential_interrupt_enable,
  input wire logic auto_zero_function,
  input wire logic auto_reference_function,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  output logic filter_reset
);
  import bosr_pkg::*;

  // ----------------------------------------
  // staging and acceptance
  // ----------------------------------------
  bosr_sample_s stg_data;
  logic stg_valid;
  logic lock_r;
  wire acc = stg_valid & ~lock_r;

  bosr_fifo #(.DW(SAMPLE_W), .DEPTH(STAGE_DEPTH)) u_stage (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(conv_valid),
    .in_ready(conv_ready),
    .in_data(conv_sample),
    .out_valid(stg_valid),
    .out_ready(~lock_r),
    .out_data(stg_data)
  );

  // ----------------------------------------
  // calibration settings
  // ----------------------------------------
  logic [THR_W-1:0] thr_r;
  logic [OFFSET_W-1:0] offset_r;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      thr_r <= THR_RESET;
      offset_r <= OFFSET_RESET;
    end
    else if (ce && cfg_wr)
    begin
      thr_r <= threshold_level;
      offset_r <= press_offset_value;
    end
  end

  wire refs_off = ~differential_interrupt_enable & ~auto_zero_function &
    ~auto_reference_function;
  wire [PRESS_W-1:0] offset_ext = {{(PRESS_W-OFFSET_W){offset_r[OFFSET_W-1]}},
    offset_r};
  wire [PRESS_W-1:0] press_cal = refs_off ?
    stg_data.press - offset_ext : stg_data.press;

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = reg_rd_en & (a == b);
  endfunction : hit

  wire rd_plow = hit(reg_addr, ADDR_PRESS_LOW);
  wire rd_phigh = hit(reg_addr, ADDR_PRESS_HIGH);
  wire rd_tlow = hit(reg_addr, ADDR_TEMP_LOW);
  wire rd_thigh = hit(reg_addr, ADDR_TEMP_HIGH);
  wire rd_qlow = hit(reg_addr, ADDR_QPRESS_LOW);
  wire rd_qlast = hit(reg_addr, ADDR_QTEMP_HIGH);
  wire rd_filter = hit(reg_addr, ADDR_FILTER_CLEAR);
  wire lock_set = rd_plow | rd_tlow | rd_qlow;
  wire lock_clr = rd_phigh | rd_thigh | rd_qlast;

  // hold off new results between first and last byte
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      lock_r <= 1'b0;
    end
    else if (ce)
    begin
      lock_r <= lock_clr ? 1'b0 : (lock_set ? 1'b1 : lock_r);
    end
  end

  // ----------------------------------------
  // live results and sample flags
  // ----------------------------------------
  logic [PRESS_W-1:0] press_r;
  logic [TEMP_W-1:0] temp_r;
  logic p_da_r;
  logic t_da_r;
  logic p_or_r;
  logic t_or_r;
  wire p_da_nxt = acc ? 1'b1 : (rd_phigh ? 1'b0 : p_da_r);
  wire t_da_nxt = acc ? 1'b1 : (rd_thigh ? 1'b0 : t_da_r);
  wire p_or_nxt = (acc & p_da_r) ? 1'b1 : (rd_phigh ? 1'b0 : p_or_r);
  wire t_or_nxt = (acc & t_da_r) ? 1'b1 : (rd_thigh ? 1'b0 : t_or_r);

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      press_r <= '0;
      temp_r <= '0;
      p_da_r <= 1'b0;
      t_da_r <= 1'b0;
      p_or_r <= 1'b0;
      t_or_r <= 1'b0;
    end
    else if (ce)
    begin
      if (acc)
      begin
        press_r <= press_cal;
        temp_r <= stg_data.temp;
      end
      p_da_r <= p_da_nxt;
      t_da_r <= t_da_nxt;
      p_or_r <= p_or_nxt;
      t_or_r <= t_or_nxt;
    end
  end

  // ----------------------------------------
  // sample queue
  // ----------------------------------------
  bosr_sample_s q_mem [128];
  logic [QUEUE_AW-1:0] q_wr_r;
  logic [QUEUE_AW-1:0] q_rd_r;
  logic [QUEUE_CW-1:0] q_cnt_r;
  logic q_ovr_r;
  wire q_full = q_cnt_r == QUEUE_DEPTH;
  wire q_pop = rd_qlast & (q_cnt_r != '0);
  wire q_lose = acc & q_full & ~q_pop;
  wire [QUEUE_CW-1:0] q_cnt_nxt = q_lose ? q_cnt_r :
    q_cnt_r + QUEUE_CW'(acc) - QUEUE_CW'(q_pop);
  bosr_sample_s q_head;
  assign q_head = q_mem[q_rd_r];

  always_ff @(posedge core_clk)
  begin
    if (ce && acc)
    begin
      q_mem[q_wr_r] <= '{press: press_cal, temp: stg_data.temp};
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      q_wr_r <= '0;
      q_rd_r <= '0;
      q_cnt_r <= '0;
      q_ovr_r <= 1'b0;
    end
    else if (ce)
    begin
      q_wr_r <= q_wr_r + QUEUE_AW'(acc);
      q_rd_r <= q_rd_r + QUEUE_AW'(q_pop | q_lose);
      q_cnt_r <= q_cnt_nxt;
      q_ovr_r <= q_lose ? 1'b1 : (q_pop ? 1'b0 : q_ovr_r);
    end
  end

  // ----------------------------------------
  // read data selection
  // ----------------------------------------
  wire thr_hit = q_cnt_r >= {1'b0, thr_r};
  wire [7:0] qflags_b = {thr_hit, q_ovr_r, q_full & ~q_ovr_r, 5'h00};
  wire [7:0] sflags_b = {2'h0, t_or_r, p_or_r, 2'h0, t_da_r, p_da_r};
  wire [7:0] rd_sel =
    (reg_addr == ADDR_QUEUE_FLAGS) ? qflags_b :
    (reg_addr == ADDR_SAMPLE_FLAGS) ? sflags_b :
    (reg_addr == ADDR_PRESS_LOW) ? press_r[7:0] :
    (reg_addr == ADDR_PRESS_MID) ? press_r[15:8] :
    (reg_addr == ADDR_PRESS_HIGH) ? press_r[23:16] :
    (reg_addr == ADDR_TEMP_LOW) ? temp_r[7:0] :
    (reg_addr == ADDR_TEMP_HIGH) ? temp_r[15:8] :
    (reg_addr == ADDR_QPRESS_LOW) ? q_head.press[7:0] :
    (reg_addr == ADDR_QPRESS_MID) ? q_head.press[15:8] :
    (reg_addr == ADDR_QPRESS_HIGH) ? q_head.press[23:16] :
    (reg_addr == ADDR_QTEMP_LOW) ? q_head.temp[7:0] :
    (reg_addr == ADDR_QTEMP_HIGH) ? q_head.temp[15:8] :
    READ_ZERO;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      reg_rd_data <= READ_ZERO;
      reg_rd_valid <= 1'b0;
      filter_reset <= 1'b0;
    end
    else if (ce)
    begin
      if (reg_rd_en)
      begin
        reg_rd_data <= rd_sel;
      end
      reg_rd_valid <= reg_rd_en;
      filter_reset <= rd_filter;
    end
  end
endmodule : bosr_readout

// ===== rtl/bosr_pkg.sv
// constants and types of the barometer readout block
// assumes one core clock and a same-clock serial register engine
package bosr_pkg;
  // register addresses
  localparam logic [7:0] ADDR_QUEUE_FLAGS = 8'h26;
  localparam logic [7:0] ADDR_SAMPLE_FLAGS = 8'h27;
  localparam logic [7:0] ADDR_PRESS_LOW = 8'h28;
  localparam logic [7:0] ADDR_PRESS_MID = 8'h29;
  localparam logic [7:0] ADDR_PRESS_HIGH = 8'h2A;
  localparam logic [7:0] ADDR_TEMP_LOW = 8'h2B;
  localparam logic [7:0] ADDR_TEMP_HIGH = 8'h2C;
  localparam logic [7:0] ADDR_FILTER_CLEAR = 8'h3C;
  localparam logic [7:0] ADDR_QPRESS_LOW = 8'h78;
  localparam logic [7:0] ADDR_QPRESS_MID = 8'h79;
  localparam logic [7:0] ADDR_QPRESS_HIGH = 8'h7A;
  localparam logic [7:0] ADDR_QTEMP_LOW = 8'h7B;
  localparam logic [7:0] ADDR_QTEMP_HIGH = 8'h7C;
  // field positions
  localparam int QF_THR_BIT = 7;
  localparam int QF_OVR_BIT = 6;
  localparam int QF_FULL_BIT = 5;
  localparam int SF_TOR_BIT = 5;
  localparam int SF_POR_BIT = 4;
  localparam int SF_TDA_BIT = 1;
  localparam int SF_PDA_BIT = 0;
  // sizes and reset values
  localparam int PRESS_W = 24;
  localparam int TEMP_W = 16;
  localparam int OFFSET_W = 16;
  localparam int THR_W = 7;
  localparam int QUEUE_AW = 7;
  localparam int QUEUE_CW = 8;
  localparam logic [7:0] QUEUE_DEPTH = 8'h80;
  localparam int STAGE_DEPTH = 4;
  localparam logic [6:0] THR_RESET = 7'h00;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [7:0] READ_ZERO = 8'h00;

  typedef struct packed {
    logic [PRESS_W-1:0] press;
    logic [TEMP_W-1:0] temp;
  } bosr_sample_s;

  localparam int SAMPLE_W = $bits(bosr_sample_s);
endpackage : bosr_pkg

// ===== testbench/bosr_monitor.sv
// assertion checker for the barometer readout top
// assumes a bind onto bosr_readout and a single core clock
`timescale 1ns/1ps
// ----------------------------------------
// readout checker
// ----------------------------------------
module bosr_monitor (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic conv_valid,
  input wire logic conv_ready,
  input wire bosr_pkg::bosr_sample_s conv_sample,
  input wire logic cfg_wr,
  input wire logic [bosr_pkg::THR_W-1:0] threshold_level,
  input wire logic [bosr_pkg::OFFSET_W-1:0] press_offset_value,
  input wire logic differential_interrupt_enable,
  input wire logic auto_zero_function,
  input wire logic auto_reference_function,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_valid,
  input wire logic filter_reset
);
  import bosr_pkg::*;
  logic thr_zero_r;
  logic rd_ok;
  logic rd_qf;
  logic rd_flt;
  assign rd_ok = reg_rd_en && ce;
  assign rd_qf = rd_ok && (reg_addr == ADDR_QUEUE_FLAGS);
  assign rd_flt = rd_ok && (reg_addr == ADDR_FILTER_CLEAR);
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      thr_zero_r <= 1'b1;
    else if (cfg_wr && ce)
      thr_zero_r <= (threshold_level == THR_RESET);
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  rd_answer_a: assert property (rd_ok |=> reg_rd_valid)
    else $error("read got no answer");
  rd_pulse_a: assert property (reg_rd_valid |-> $past(rd_ok))
    else $error("answer without read");
  data_hold_a: assert property (!rd_ok |=> $stable(reg_rd_data))
    else $error("read data moved without read");
  flt_pulse_a: assert property (rd_flt |=> filter_reset
    && reg_rd_data == READ_ZERO) else $error("filter clear missed");
  flt_cause_a: assert property (filter_reset |-> $past(rd_flt))
    else $error("filter clear without read");
  thr_zero_a: assert property (rd_qf && thr_zero_r
    |=> reg_rd_data[QF_THR_BIT]) else $error("threshold flag low");
  full_excl_a: assert property (rd_qf |=> !(reg_rd_data[QF_OVR_BIT]
    && reg_rd_data[QF_FULL_BIT])) else $error("filled and overwrite");
  sflag_rsv_a: assert property (rd_ok && reg_addr == ADDR_SAMPLE_FLAGS
    |=> reg_rd_data[7:6] == 2'h0 && reg_rd_data[3:2] == 2'h0)
    else $error("sample flag spare bits set");
  ready_fall_a: assert property ($fell(conv_ready) |-> $past(conv_valid))
    else $error("ready dropped without sample");
endmodule : bosr_monitor

bind bosr_readout bosr_monitor u_mon (.*);

// ===== testbench/bosr_host.sv
// host model reading registers of the readout block
// assumes one read pulse per request, answer one cycle later
`timescale 1ns/1ps
// ----------------------------------------
// register reader
// ----------------------------------------
module bosr_host (
  input wire logic core_clk,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  input wire logic reg_rd_valid,
  input wire logic [7:0] reg_rd_data
);
  initial
  begin
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
  end
  // answer is registered at the edge that takes the read; look once settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    #1;
    d = (reg_rd_valid === 1'b1) ? reg_rd_data : 8'hXX;
  endtask : rd
endmodule : bosr_host

// ===== testbench/bosr_readout_bench.sv
// self-checking bench of the barometer readout block
// assumes host model and checker files compiled alongside
`timescale 1ns/1ps
// ----------------------------------------
// bench
// ----------------------------------------
module bosr_readout_bench;
  import bosr_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic conv_valid = 1'b0;
  logic conv_ready;
  bosr_sample_s conv_sample = '0;
  logic cfg_wr = 1'b0;
  logic [THR_W-1:0] thr = '0;
  logic [OFFSET_W-1:0] off = '0;
  logic mode_off = 1'b0;
  logic reg_rd_en, reg_rd_valid, filter_reset;
  logic [7:0] reg_addr, reg_rd_data;
  int errors = 0;
  int check_count = 0;
  always #2 core_clk = ~core_clk;
  bosr_readout u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce),
    .conv_valid(conv_valid), .conv_ready(conv_ready),
    .conv_sample(conv_sample), .cfg_wr(cfg_wr), .threshold_level(thr),
    .press_offset_value(off), .differential_interrupt_enable(mode_off),
    .auto_zero_function(mode_off), .auto_reference_function(mode_off),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .filter_reset(filter_reset));
  bosr_host u_host (.core_clk(core_clk), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_rd_valid(reg_rd_valid),
    .reg_rd_data(reg_rd_data));
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    check_count++;
    if (d !== e)
    begin
      errors++;
      $display("MISMATCH reg %h exp %h got %h", a, e, d);
    end
  endtask : rc
  task automatic rv(input logic [7:0] b, input logic [23:0] p,
    input logic [15:0] t);
    rc(b, p[7:0]);
    rc(b + 8'h01, p[15:8]);
    rc(b + 8'h02, p[23:16]);
    rc(b + 8'h03, t[7:0]);
    rc(b + 8'h04, t[15:8]);
  endtask : rv
  function automatic logic [23:0] ep(input logic [23:0] r);
    return r - {{8{off[15]}}, off};
  endfunction : ep
  task automatic push(input logic [23:0] p, input logic [15:0] t);
    int n = 0;
    @(posedge core_clk);
    conv_valid <= 1'b1;
    conv_sample <= '{press: p, temp: t};
    #1;
    // ready is registered: its settled value is what the next edge samples
    while (conv_ready !== 1'b1 && n < 50)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
    conv_valid <= 1'b0;
    if (n >= 50) errors++;
  endtask : push
  task automatic cfg(input logic [6:0] t, input logic [15:0] o);
    @(posedge core_clk);
    cfg_wr <= 1'b1;
    thr <= t;
    off <= o;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
  endtask : cfg
  task automatic t_reset();
    rc(ADDR_QUEUE_FLAGS, 8'h80);
    rc(ADDR_SAMPLE_FLAGS, 8'h00);
    rc(ADDR_FILTER_CLEAR, READ_ZERO);
    rc(8'h55, 8'h00);
  endtask : t_reset
  task automatic t_live();
    logic [23:0] e;
    cfg(7'h00, 16'hFFF0);
    push(24'h123456, 16'hABCD);
    repeat (6) @(posedge core_clk);
    rc(ADDR_SAMPLE_FLAGS, 8'h03);
    e = ep(24'h123456);
    rc(ADDR_PRESS_LOW, e[7:0]);
    push(24'h800000, 16'h0102);
    repeat (6) @(posedge core_clk);
    rc(ADDR_PRESS_MID, e[15:8]);
    rc(ADDR_PRESS_HIGH, e[23:16]);
    repeat (6) @(posedge core_clk);
    rc(ADDR_SAMPLE_FLAGS, 8'h23);
    rc(ADDR_TEMP_LOW, 8'h02);
    rc(ADDR_TEMP_HIGH, 8'h01);
    rc(ADDR_SAMPLE_FLAGS, 8'h01);
    rv(ADDR_PRESS_LOW, ep(24'h800000), 16'h0102);
    rc(ADDR_SAMPLE_FLAGS, 8'h00);
  endtask : t_live
  task automatic t_over();
    push(24'hFEDCBA, 16'h8001);
    push(24'h000001, 16'h7FFF);
    repeat (6) @(posedge core_clk);
    rc(ADDR_SAMPLE_FLAGS, 8'h33);
    rv(ADDR_PRESS_LOW, ep(24'h000001), 16'h7FFF);
    rc(ADDR_SAMPLE_FLAGS, 8'h00);
  endtask : t_over
  task automatic t_queue();
    rv(ADDR_QPRESS_LOW, ep(24'h123456), 16'hABCD);
    cfg(7'h03, 16'hFFF0);
    rc(ADDR_QUEUE_FLAGS, 8'h80);
    cfg(7'h04, 16'hFFF0);
    rc(ADDR_QUEUE_FLAGS, 8'h00);
  endtask : t_queue
  task automatic t_full();
    for (int i = 0; i < 125; i++)
      push(24'(i), 16'(i));
    repeat (6) @(posedge core_clk);
    rc(ADDR_QUEUE_FLAGS, 8'hA0);
    push(24'h0000AA, 16'h00AA);
    repeat (6) @(posedge core_clk);
    rc(ADDR_QUEUE_FLAGS, 8'hC0);
    rv(ADDR_QPRESS_LOW, ep(24'hFEDCBA), 16'h8001);
    rc(ADDR_QUEUE_FLAGS, 8'h80);
  endtask : t_full
  task automatic results();
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  initial
  begin
    #80000;
    errors++;
    results();
  end
  initial
  begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_live();
    t_over();
    t_queue();
    t_full();
    results();
  end
endmodule : bosr_readout_bench
